// ### sirq_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"
module sirq_ctrl #(
	parameter SLOTS = 16
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        ch2_out_full_flag_i,
	input  wire        ch4a_out_full_flag_i,
	input  wire        ch4b_out_full_flag_i,
	input  wire        serial_port_irq_req_i,
	input  wire        lpc_sw_reset_i,
	input  wire        lpc_reset_n_i,
	input  wire        lclk_i,
	input  wire        serirq_i,
	output reg         serirq_o,
	output reg         serirq_oe_o,
	output reg  [15:0] host_irq_req_o,
	output reg  [15:0] serial_port_addr_o,
	output reg         ch3_direct_mode_o,
	output reg         irq_o
);

// ---------------------------------------------------------------
// code decoding, shared by both selectable sources
// ---------------------------------------------------------------
function [15:0] code_vec;
	input [3:0] code;
	begin
		if (code == 4'h0)
			code_vec = 16'h0000;
		else
			code_vec = 16'h0001 << code;
	end
endfunction

// ---------------------------------------------------------------
// pin synchronisers
// ---------------------------------------------------------------
// lclk, the serial line and link reset are pins: two flops first
reg lclk_s1;
reg lclk_s2;
reg lclk_s3;
reg sirq_s1;
reg sirq_s2;
reg lrst_s1;
reg lrst_s2;

always @(posedge clk_i) begin
	if (rst_i) begin
		lclk_s1 <= 1'b0;
		lclk_s2 <= 1'b0;
		lclk_s3 <= 1'b0;
		sirq_s1 <= 1'b1;
		sirq_s2 <= 1'b1;
		lrst_s1 <= 1'b1;
		lrst_s2 <= 1'b1;
	end else begin
		lclk_s1 <= lclk_i;
		lclk_s2 <= lclk_s1;
		lclk_s3 <= lclk_s2;
		sirq_s1 <= serirq_i;
		sirq_s2 <= sirq_s1;
		lrst_s1 <= lpc_reset_n_i;
		lrst_s2 <= lrst_s1;
	end
end

wire lclk_rise = lclk_s2 & ~lclk_s3;
// either link reset clears the enables, as does the local reset
wire lpc_rst   = rst_i | ~lrst_s2 | lpc_sw_reset_i;

// ---------------------------------------------------------------
// wishbone slave
// ---------------------------------------------------------------
// effects happen on the edge where ack is sampled high
// one wait state: registered ack keeps read data settled
wire bus_req = wb_cyc_i & wb_stb_i;
wire wr_acc  = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
wire rd_acc  = bus_req & wb_ack_o & ~wb_we_i;
wire [7:0] d = wb_dat_i[7:0];

reg  [7:0] en;
reg  [7:0] arm;
reg        dir2;
reg        dir4;
reg  [7:0] pol;
reg  [3:0] bidir_irq_code;
reg  [3:0] serial_port_irq_code;
reg  [3:0] st;
reg  [3:0] ien;
reg  [7:0] rd_mux;

always @* begin
	rd_mux = 8'h00;
	if (wb_adr_i == `SIRQ_OFS_CTRL1)
		rd_mux = {2'b00, dir2, 3'b000, en[1:0]};
	else if (wb_adr_i == `SIRQ_OFS_CTRL2)
		rd_mux = {ch3_direct_mode_o, dir4, en[6:2], 1'b0};
	else if (wb_adr_i == `SIRQ_OFS_POL3)
		rd_mux = pol;
	else if (wb_adr_i == `SIRQ_OFS_SRC4)
		rd_mux = {bidir_irq_code, serial_port_irq_code};
	else if (wb_adr_i == `SIRQ_OFS_CTRL5)
		rd_mux = {en[7], 7'h00};
	else if (wb_adr_i == `SIRQ_OFS_ADRH)
		rd_mux = serial_port_addr_o[15:8];
	else if (wb_adr_i == `SIRQ_OFS_ADRL)
		rd_mux = serial_port_addr_o[7:0];
	else if (wb_adr_i == `SIRQ_OFS_STAT)
		rd_mux = {4'h0, st};
	else if (wb_adr_i == `SIRQ_OFS_IEN)
		rd_mux = {4'h0, ien};
	else if (wb_adr_i == `SIRQ_OFS_FLAGS)
		rd_mux = {5'h00, ch4b_out_full_flag_i,
			ch4a_out_full_flag_i, ch2_out_full_flag_i};
end

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
	end else begin
		wb_ack_o <= bus_req & ~wb_ack_o;
		if (bus_req & ~wb_ack_o)
			wb_dat_o <= {24'h000000, rd_mux};
		else
			wb_dat_o <= 32'h00000000;
	end
end

// ---------------------------------------------------------------
// plain control registers
// ---------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		dir2                 <= 1'b0;
		dir4                 <= 1'b0;
		ch3_direct_mode_o    <= 1'b0;
		pol                  <= `SIRQ_RST_BYTE;
		bidir_irq_code       <= 4'h0;
		serial_port_irq_code <= 4'h0;
		serial_port_addr_o   <= {`SIRQ_RST_ADRH, `SIRQ_RST_ADRL};
		ien                  <= 4'h0;
	end else if (wr_acc) begin
		if (wb_adr_i == `SIRQ_OFS_CTRL1) begin
			dir2 <= d[`SIRQ_BIT_DIR2]; // RQ17
		end else if (wb_adr_i == `SIRQ_OFS_CTRL2) begin
			ch3_direct_mode_o <= d[`SIRQ_BIT_DIR3]; // RQ5
			dir4              <= d[`SIRQ_BIT_DIR4]; // RQ6
		end else if (wb_adr_i == `SIRQ_OFS_POL3) begin
			pol <= d; // RQ9
		end else if (wb_adr_i == `SIRQ_OFS_SRC4) begin
			bidir_irq_code       <= d[7:4]; // RQ10
			serial_port_irq_code <= d[3:0]; // RQ11
		end else if (wb_adr_i == `SIRQ_OFS_ADRH) begin
			serial_port_addr_o[15:8] <= d; // RQ13
		end else if (wb_adr_i == `SIRQ_OFS_ADRL) begin
			serial_port_addr_o[7:0] <= d; // RQ13
		end else if (wb_adr_i == `SIRQ_OFS_IEN) begin
			ien <= d[3:0];
		end
	end
end

// ---------------------------------------------------------------
// channel enables
// ---------------------------------------------------------------
// bit map: 0 ch2 irq6, 1 ch2 irq9, 2 ch4 smi, 3 ch4 irq6,
// 4 ch4 irq9, 5 ch4 irq10, 6 ch4 irq11, 7 ch4b
reg f2_d;
reg f4a_d;
reg f4b_d;

always @(posedge clk_i) begin
	if (rst_i) begin
		f2_d  <= 1'b0;
		f4a_d <= 1'b0;
		f4b_d <= 1'b0;
	end else begin
		f2_d  <= ch2_out_full_flag_i;
		f4a_d <= ch4a_out_full_flag_i;
		f4b_d <= ch4b_out_full_flag_i;
	end
end

wire [7:0] src_flag = {ch4b_out_full_flag_i, {5{ch4a_out_full_flag_i}},
	{2{ch2_out_full_flag_i}}};
wire [7:0] src_prev = {f4b_d, {5{f4a_d}}, {2{f2_d}}};
wire [7:0] src_dir  = {{6{dir4}}, {2{dir2}}};
wire [7:0] src_fall = src_prev & ~src_flag;

wire [7:0] reg_mask =
	(wb_adr_i == `SIRQ_OFS_CTRL1) ? 8'h03 :
	(wb_adr_i == `SIRQ_OFS_CTRL2) ? 8'h7C :
	(wb_adr_i == `SIRQ_OFS_CTRL5) ? 8'h80 : 8'h00;
// the three registers hold disjoint slices of the same vector
wire [7:0] wr_val   = {d[`SIRQ_BIT_EN4B], d[5:1], d[1:0]};
wire [7:0] wr_mask  = reg_mask & {8{wr_acc}};
wire [7:0] rd_mask  = reg_mask & {8{rd_acc}};

wire [7:0] active;

genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_en
		always @(posedge clk_i) begin
			if (rst_i) begin
				arm[gi] <= 1'b0;
			end else if (rd_mask[gi]) begin
				arm[gi] <= ~en[gi]; // RQ4
			end else if (wr_mask[gi]) begin
				arm[gi] <= 1'b0;
			end
		end
		always @(posedge clk_i) begin
			if (lpc_rst) begin
				en[gi] <= 1'b0; // RQ3
			end else if (wr_mask[gi] & wr_val[gi] & arm[gi]) begin
				en[gi] <= 1'b1; // RQ4
			end else if (wr_mask[gi] & ~wr_val[gi]) begin
				en[gi] <= 1'b0; // RQ3
			end else if (src_fall[gi] & ~src_dir[gi]) begin
				en[gi] <= 1'b0; // RQ3
			end
		end
		// direct mode needs only the enable
		assign active[gi] = en[gi] & (src_dir[gi] | src_flag[gi]); // RQ8
	end
endgenerate

// ---------------------------------------------------------------
// request routing
// ---------------------------------------------------------------
reg [15:0] next_req;

always @* begin
	next_req = 16'h0000;
	next_req[6]  = active[0] | active[3]; // RQ2 RQ7
	next_req[9]  = active[1] | active[4]; // RQ1 RQ7
	next_req[2]  = active[2]; // RQ7
	next_req[10] = active[5]; // RQ7
	next_req[11] = active[6]; // RQ7
	next_req = next_req
		| (code_vec(bidir_irq_code) & {16{active[7]}}) // RQ12
		| (code_vec(serial_port_irq_code)
		& {16{serial_port_irq_req_i}}); // RQ11 RQ18
end

// only lines 15,14,13,8,7,5,4,3 have a selectable polarity
wire [15:0] pol16 = {pol[7:5], 4'h0, pol[4:3], 1'b0, pol[2:0], 3'h0};

always @(posedge clk_i) begin
	if (rst_i)
		host_irq_req_o <= 16'h0000;
	else
		host_irq_req_o <= next_req; // RQ18
end

// ---------------------------------------------------------------
// serial frame engine
// ---------------------------------------------------------------
localparam [2:0] S_IDLE  = 3'b001;
localparam [2:0] S_START = 3'b010;
localparam [2:0] S_SLOT  = 3'b100;

reg [2:0] state;
reg [3:0] low_cnt;
reg [4:0] slot;
reg [1:0] phase;
reg       frame_done;

wire [4:0] slot_nx  = slot + 5'h01;
// pin is driven low when request and polarity disagree
wire       drive_lo = host_irq_req_o[slot_nx[3:0]] ^ pol16[slot_nx[3:0]];

always @(posedge clk_i) begin
	if (rst_i) begin
		state       <= S_IDLE;
		low_cnt     <= 4'h0;
		slot        <= `SIRQ_SLOT_PRE;
		phase       <= `SIRQ_PH_TURN;
		serirq_o    <= 1'b1;
		serirq_oe_o <= 1'b0;
		frame_done  <= 1'b0;
	end else begin
		frame_done <= 1'b0;
		if (lclk_rise) begin
			case (state)
			S_IDLE: begin
				serirq_oe_o <= 1'b0;
				if (~sirq_s2) begin
					low_cnt <= 4'h1;
					state   <= S_START;
				end
			end
			S_START: begin
				if (~sirq_s2) begin
					if (low_cnt != 4'hF)
						low_cnt <= low_cnt + 4'h1;
				end else if (low_cnt >= `SIRQ_START_MIN) begin
					slot  <= `SIRQ_SLOT_PRE;
					phase <= `SIRQ_PH_TURN;
					state <= S_SLOT;
				end else begin
					state <= S_IDLE;
				end
			end
			S_SLOT: begin
				if (phase == `SIRQ_PH_TURN) begin
					serirq_oe_o <= 1'b0;
					if (slot == SLOTS - 1) begin
						frame_done <= 1'b1;
						state      <= S_IDLE;
					end else begin
						slot        <= slot_nx;
						phase       <= `SIRQ_PH_SAMPLE;
						serirq_o    <= 1'b0;
						serirq_oe_o <= drive_lo; // RQ9 RQ18
					end
				end else if (phase == `SIRQ_PH_SAMPLE) begin
					// drive high one edge so the line recovers fast
					serirq_o <= 1'b1;
					phase    <= `SIRQ_PH_RECOV;
				end else begin
					serirq_oe_o <= 1'b0;
					phase       <= `SIRQ_PH_TURN;
				end
			end
			default: begin
				state       <= S_IDLE;
				serirq_oe_o <= 1'b0;
			end
			endcase
		end
	end
end

// ---------------------------------------------------------------
// local interrupt
// ---------------------------------------------------------------
// irq_o trails the status bits by one cycle
wire [3:0] ev = {frame_done,
	ch4b_out_full_flag_i & ~f4b_d,
	ch4a_out_full_flag_i & ~f4a_d,
	ch2_out_full_flag_i & ~f2_d};
wire [3:0] clr = (wr_acc && wb_adr_i == `SIRQ_OFS_ICLR) ?
	d[3:0] : 4'h0;

always @(posedge clk_i) begin
	if (rst_i) begin
		st    <= 4'h0;
		irq_o <= 1'b0;
	end else begin
		// a new event beats a clear in the same cycle
		st    <= (st & ~clr) | ev;
		irq_o <= |(st & ien);
	end
end

endmodule // sirq_ctrl
`default_nettype wire

// ### sirq_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"
module sirq_ctrl_assertions #(
	parameter SLOTS = 16
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        lpc_sw_reset_i,
	input wire logic        serial_port_irq_req_i,
	input wire logic        serirq_o,
	input wire logic        serirq_oe_o,
	input wire logic [15:0] host_irq_req_o,
	input wire logic [15:0] serial_port_addr_o,
	input wire logic        ch3_direct_mode_o
);
	// ---------------------------------------------------------------
	// port relations
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_low;
		serirq_oe_o && !serirq_o;
	endsequence
	sequence s_rec;
		serirq_oe_o && serirq_o;
	endsequence
	a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	// reset itself is checked, so no disable here
	a_reset_state: assert property (disable iff (1'b0) rst_i |=>
		serirq_o && !serirq_oe_o && host_irq_req_o == 16'h0000 &&
		serial_port_addr_o == {`SIRQ_RST_ADRH, `SIRQ_RST_ADRL})
		else $error("bad reset state");
	a_addr_write: assert property ($changed(serial_port_addr_o) |->
		$past(rst_i) || $past(wb_ack_o && wb_we_i &&
		(wb_adr_i == `SIRQ_OFS_ADRH || wb_adr_i == `SIRQ_OFS_ADRL)))
		else $error("address moved without write");
	a_dir3_write: assert property ($changed(ch3_direct_mode_o) |->
		$past(rst_i) || $past(wb_ack_o && wb_we_i &&
		wb_adr_i == `SIRQ_OFS_CTRL2)) else $error("direct bit moved");
	a_sw_clear: assert property (lpc_sw_reset_i && !serial_port_irq_req_i
		##1 !serial_port_irq_req_i |=> host_irq_req_o == 16'h0000)
		else $error("request after lpc reset");
	a_drive_low: assert property ($rose(serirq_oe_o) |-> !serirq_o)
		else $error("drive not low");
	a_low_ends: assert property (s_low |-> ##[1:12] s_rec)
		else $error("sample phase too long");
	a_rec_release: assert property (s_low ##1 s_rec |->
		##[1:12] !serirq_oe_o) else $error("line not released");
endmodule // sirq_ctrl_assertions
`default_nettype wire

// ### sirq_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"
module sirq_ctrl_test;
	localparam int         SL = 16;
	localparam logic [7:0] C1 = `SIRQ_OFS_CTRL1;
	localparam logic [7:0] C2 = `SIRQ_OFS_CTRL2;
	localparam logic [7:0] C5 = `SIRQ_OFS_CTRL5;
	localparam logic [7:0] SR = `SIRQ_OFS_SRC4;
	logic        clk_i, rst_i, cyc, stb, we, sp_req, sw_rst, hw_n;
	logic [7:0]  adr, q, a;
	logic [31:0] dat;
	logic [2:0]  flg;
	logic [3:0]  c;
	wire  [31:0] dat_o;
	wire  [15:0] req, addr;
	wire         ack, so, soe, lclk, line, dir3, irq;
	integer      errors, samples_checked, i;
	int          tbit[8] = '{0, 1, 5, 4, 3, 2, 1, 7};
	int          tirq[8] = '{6, 9, 11, 10, 9, 6, 2, 13};
	int          tflg[8] = '{0, 0, 1, 1, 1, 1, 1, 2};
	sirq_ctrl #(.SLOTS(SL)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ch2_out_full_flag_i(flg[0]), .ch4a_out_full_flag_i(flg[1]),
		.ch4b_out_full_flag_i(flg[2]), .serial_port_irq_req_i(sp_req),
		.lpc_sw_reset_i(sw_rst), .lpc_reset_n_i(hw_n), .lclk_i(lclk),
		.serirq_i(line), .serirq_o(so), .serirq_oe_o(soe),
		.host_irq_req_o(req), .serial_port_addr_o(addr),
		.ch3_direct_mode_o(dir3), .irq_o(irq));
	sirq_host #(.SLOTS(SL)) i_host (.serirq_o(so), .serirq_oe_o(soe),
		.lclk_o(lclk), .serirq_w_o(line));
	// ---------------------------------------------------------------
	// bus and compare tasks
	// ---------------------------------------------------------------
	task wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= {24'h0, d};
			do @(posedge clk_i); while (ack !== 1'b1);
			q = dat_o[7:0];
			cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		end
	endtask
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task rdc(input string nm, input logic [7:0] ad, input logic [7:0] e);
		wb(1'b0, ad, 8'h00);
		chk(nm, {8'h00, q}, {8'h00, e});
	endtask
	// enables only take a 1 after a read has armed them
	task en(input logic [7:0] ad, input logic [7:0] d);
		wb(1'b0, ad, 8'h00);
		wb(1'b1, ad, d);
	endtask
	task settle;
		repeat (4) @(posedge clk_i);
	endtask
	function logic [15:0] m(input int k);
		m = (k == 0) ? 16'h0000 : 16'h0001 << k;
	endfunction
	task print_verdict;
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#400000 errors++;
		print_verdict;
	end
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		{cyc, stb, we, sp_req, sw_rst, flg} = '0;
		hw_n = 1'b1; adr = 8'h00; dat = 32'h0; errors = 0;
		samples_checked = 0; rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc("adrh", `SIRQ_OFS_ADRH, 8'h03);
		rdc("adrl", `SIRQ_OFS_ADRL, 8'hF8);
		rdc("ctrl2", C2, 8'h00);
		rdc("unmapped", 8'h40, 8'h00);
		wb(1'b1, C1, 8'h02);
		rdc("noarm", C1, 8'h00);
		wb(1'b1, SR, 8'hD0);
		for (i = 0; i < 8; i++) begin
			a = (tflg[i] == 0) ? C1 : (tflg[i] == 1) ? C2 : C5;
			en(a, 8'h01 << tbit[i]);
			settle;
			chk("idle", req, 16'h0000);
			flg[tflg[i]] <= 1'b1;
			settle;
			chk("route", req, m(tirq[i]));
			flg[tflg[i]] <= 1'b0;
			settle;
			rdc("autoclr", a, 8'h00);
		end
		wb(1'b1, `SIRQ_OFS_IEN, 8'h01);
		settle;
		chk("irq", {15'h0, irq}, 16'h0001);
		wb(1'b1, `SIRQ_OFS_ICLR, 8'h01);
		settle;
		chk("irqclr", {15'h0, irq}, 16'h0000);
		rdc("status", `SIRQ_OFS_STAT, 8'h06);
		wb(1'b1, `SIRQ_OFS_IEN, 8'h02);
		settle;
		chk("irq4a", {15'h0, irq}, 16'h0001);
		wb(1'b1, `SIRQ_OFS_ICLR, 8'h06);
		rdc("iclr", `SIRQ_OFS_ICLR, 8'h00);
		chk("irqoff", {15'h0, irq}, 16'h0000);
		en(C2, 8'hD0);
		settle;
		chk("direct", req, m(10));
		chk("dir3", {15'h0, dir3}, 16'h0001);
		en(C1, 8'h21);
		settle;
		chk("or", req, m(10) | m(6));
		sw_rst <= 1'b1;
		@(posedge clk_i);
		sw_rst <= 1'b0;
		settle;
		chk("swrst", req, 16'h0000);
		rdc("dirkeep", C2, 8'hC0);
		en(C2, 8'hD0);
		hw_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		hw_n <= 1'b1;
		settle;
		chk("hwrst", req, 16'h0000);
		en(C5, 8'h80);
		sp_req <= 1'b1;
		for (i = 0; i < 16; i++) begin
			c = i;
			wb(1'b1, SR, {c, ~c});
			settle;
			chk("code", req, m(i) | m(15 - i));
		end
		wb(1'b1, SR, 8'h05);
		wb(1'b1, C5, 8'h00);
		wb(1'b1, `SIRQ_OFS_POL3, 8'h81);
		wb(1'b1, `SIRQ_OFS_ADRH, 8'h12);
		wb(1'b1, `SIRQ_OFS_ADRL, 8'h34);
		settle;
		chk("addr", addr, 16'h1234);
		i_host.frame();
		for (i = 0; i < 16; i++)
			chk("slot", {15'h0, i_host.seen[i]},
				(i == 3 || i == 5 || i == 15) ? 16'h0 : 16'h1);
		rdc("frame", `SIRQ_OFS_STAT, 8'h08);
		print_verdict;
	end
endmodule // sirq_ctrl_test
bind sirq_ctrl sirq_ctrl_assertions #(.SLOTS(SLOTS)) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.lpc_sw_reset_i(lpc_sw_reset_i),
	.serial_port_irq_req_i(serial_port_irq_req_i), .serirq_o(serirq_o),
	.serirq_oe_o(serirq_oe_o), .host_irq_req_o(host_irq_req_o),
	.serial_port_addr_o(serial_port_addr_o),
	.ch3_direct_mode_o(ch3_direct_mode_o));
`default_nettype wire

// ### sirq_defines.vh
// Operation
// RQ1: ch2 irq9 enable plus full flag requests irq9
// RQ2: ch2 irq6 enable bit0 routes full to irq6
// RQ3: enables clear on 0 write, resets, flag drop
// RQ4: enable sets only by 1 after reading 0
// RQ5: ch3 direct bit7 selects enable-only request rule
// RQ6: ch4 direct bit6 selects enable-only request rule
// RQ7: ch4 bits5..1 route to irq11,10,9,6,smi
// RQ8: direct mode enable requests regardless of flag
// RQ9: polarity select swaps hi-z and low output
// RQ10: bidir code picks none, smi or irq n
// RQ11: serial port code uses same irq coding
// RQ12: ch4b enable bit7 requests via bidir code
// RQ13: sixteen bit serial port host address register
// RQ14: software keeps address fixed while port enabled
// RQ15: software keeps channel addresses distinct from port
// RQ16: software keeps reserved bits at zero
// RQ17: ch2 direct bit selects enable-only request rule
// RQ18: per-line request is or of routed sources
`ifndef SIRQ_DEFINES_VH
`define SIRQ_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SIRQ_OFS_CTRL1   8'h00
`define SIRQ_OFS_CTRL2   8'h04
`define SIRQ_OFS_POL3    8'h08
`define SIRQ_OFS_SRC4    8'h0C
`define SIRQ_OFS_CTRL5   8'h10
`define SIRQ_OFS_ADRH    8'h14
`define SIRQ_OFS_ADRL    8'h18
`define SIRQ_OFS_STAT    8'h1C
`define SIRQ_OFS_IEN     8'h20
`define SIRQ_OFS_ICLR    8'h24
`define SIRQ_OFS_FLAGS   8'h28

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SIRQ_BIT_DIR2    5
`define SIRQ_BIT_DIR3    7
`define SIRQ_BIT_DIR4    6
`define SIRQ_BIT_EN4B    7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SIRQ_RST_ADRH    8'h03
`define SIRQ_RST_ADRL    8'hF8
`define SIRQ_RST_BYTE    8'h00

// ---------------------------------------------------------------
// serial frame timing, in link clock edges
// ---------------------------------------------------------------
`define SIRQ_START_MIN   4'h4
`define SIRQ_PH_SAMPLE   2'h0
`define SIRQ_PH_RECOV    2'h1
`define SIRQ_PH_TURN     2'h2
`define SIRQ_SLOT_PRE    5'h1F

`endif

// ### sirq_host.sv
`timescale 1ns/1ps
`default_nettype none
module sirq_host #(
	parameter SLOTS = 16
) (
	input  wire logic  serirq_o,
	input  wire logic  serirq_oe_o,
	output var  logic  lclk_o,
	output wire logic  serirq_w_o
);
	// ---------------------------------------------------------------
	// host side of the serial line
	// ---------------------------------------------------------------
	logic        host_low;
	logic [15:0] seen;
	// pull-up: only a party pulling low moves the line
	assign serirq_w_o = !(host_low || (serirq_oe_o && !serirq_o));
	initial begin
		lclk_o = 1'b0;
		host_low = 1'b0;
		seen = 16'hFFFF;
	end
	// lclk stands still between frames; offset keeps it off clk edges
	task frame;
		integer i;
		begin
			#3 host_low = 1'b1;
			for (i = 0; i < 8 + 3 * SLOTS; i++) begin
				lclk_o = 1'b1;
				#100 lclk_o = 1'b0;
				#50 host_low = (i < 3);
				#50;
				if (i >= 5 && (i - 5) % 3 == 0 && (i - 5) / 3 < 16)
					seen[(i - 5) / 3] = serirq_w_o;
			end
		end
	endtask
endmodule // sirq_host
`default_nettype wire
